// File: verilog/rcw_pkg.sv
// Constants, types and register map of the reset controller with watchdog.
// Assumes a 20 MHz clock, APB register access and a separate basic timer.
//
// Overview of operation
// RULE1: Supply and enable rising together give one start from zero, by power-on reset.
// RULE2: Enable rising during power-on forced halt still gives a single power-on start.
// RULE3: Enable rising after program start restarts from zero at next carry pulse.
// RULE4: After clock stop release, threshold switches to 3.5 V half a carry later.
// RULE5: Wake from clock stop by interrupt or port input finishes as enable reset.
// RULE6: Reset pin low holds reset, stops oscillator, halts and initialises state.
// RULE7: Reset pin high restarts oscillator, 100 ms carry, start on pulse 50 ms later.
// RULE8: Watchdog interval elapsing uncleared issues reset and restart from zero.
// RULE9: Watchdog counter holds still in clock stop or halt.
// RULE10: Watchdog or stack reset spares stack enable, clear, carry and carry counter.
// RULE11: Watchdog or stack reset sets cause flag at 16H bit 0, read clears it.
// RULE12: Interval select bits take one write after power-on or pin reset only.
// RULE13: Interval code 00 off, 01 65536, 11 131072, 10 prohibited.
// RULE14: Interval select defaults to 131072 instructions after supply application.
// RULE15: Software clears watchdog within one interval less one instruction.
// RULE16: Writing 1 to watchdog clear bit resets the watchdog counter.
// RULE17: Enabled interrupt or address stack overflow or underflow causes reset.
// RULE18: Stack reset enable register holds two enables and takes one write.
// RULE19: Enable reset takes effect at first carry pulse after enable goes high.
// RULE20: Interval select and stack enables survive watchdog, enable resets, clock stop.
`default_nettype none
package rcw_pkg;
  localparam logic [11:0] ADDR_WD_SEL    = 12'h008;
  localparam logic [11:0] ADDR_WD_CLEAR  = 12'h00C;
  localparam logic [11:0] ADDR_CAUSE     = 12'h058;
  localparam logic [11:0] ADDR_STACK_EN  = 12'h05C;
  localparam logic [11:0] ADDR_STATUS    = 12'h060;
  localparam int          INDEX_WD_SEL   = 2;
  localparam int          INDEX_CAUSE    = 22;
  localparam logic [1:0]  WD_SEL_OFF     = 2'h0;
  localparam logic [1:0]  WD_SEL_SHORT   = 2'h1;
  localparam logic [1:0]  WD_SEL_BAD     = 2'h2;
  localparam logic [1:0]  WD_SEL_LONG    = 2'h3;
  localparam logic [1:0]  WD_SEL_RESET   = 2'h3;
  localparam logic [1:0]  STACK_EN_RESET = 2'h3;
  localparam logic [17:0] WD_SHORT_COUNT = 18'h10000;
  localparam logic [17:0] WD_LONG_COUNT  = 18'h20000;
  localparam int          BIT_CLEAR      = 0;
  localparam int          BIT_ADDR_EN    = 1;
  localparam int          BIT_INT_EN     = 0;
  localparam int          ST_POR_HALT    = 0;
  localparam int          ST_RUN         = 1;
  localparam int          ST_STOP        = 2;
  localparam int          ST_CE_WAIT     = 3;
  localparam int          ST_HIGH_THR    = 4;

  typedef enum logic [4:0]
  {
    RCW_HALT_POR = 5'b00001,
    RCW_RUN      = 5'b00010,
    RCW_STOPPED  = 5'b00100,
    RCW_CE_WAIT  = 5'b01000,
    RCW_PIN_HOLD = 5'b10000
  } rcw_mode_type;

  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcw_apb_req_type;

  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rcw_apb_rsp_type;

  typedef struct packed
  {
    rcw_mode_type mode;
    logic [1:0]   wd_sel;
    logic         wd_sel_written;
    logic [1:0]   stack_en;
    logic         stack_en_written;
    logic [17:0]  wd_count;
    logic         cause_flag;
    logic         high_threshold;
    logic         half_pending;
    logic         ce_seen;
    logic         cpu_reset;
    logic         start_pulse;
    logic         osc_enable;
    logic         carry_init;
    logic         poc_sensed;
    logic [31:0]  rdata;
  } rcw_state_type;

  function automatic logic [17:0] rcw_limit(input logic [1:0] sel);
    case (sel)
      WD_SEL_SHORT: rcw_limit = WD_SHORT_COUNT;
      WD_SEL_LONG:  rcw_limit = WD_LONG_COUNT;
      default:      rcw_limit = 18'h00000;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: verilog/rcw_reset_controller.sv
// Reset controller with watchdog and stack fault reset, APB slave.
// Assumes the basic timer supplies a one-cycle carry pulse and an instruction strobe
// comes from the core; analogue supply comparison is done outside.
`default_nettype none
module rcw_reset_controller
  import rcw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        supply_low,
  input  wire logic        ce_pin,
  input  wire logic        reset_pin_b,
  input  wire logic        carry_pulse,
  input  wire logic        half_carry_pulse,
  input  wire logic        instr_done,
  input  wire logic        halt_active,
  input  wire logic        stop_request,
  input  wire logic        ext_int_wake,
  input  wire logic        port_wake_input,
  input  wire logic        int_stack_fault,
  input  wire logic        addr_stack_fault,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             cpu_reset,
  output logic             start_from_zero,
  output logic             osc_enable,
  output logic             carry_init_100ms,
  output logic             high_threshold
);

  //////////////////////////////////////////////////////////////////////////////
  rcw_state_type s_q;
  rcw_state_type s_d;
  logic          wr;
  logic          rd;
  logic          mapped;
  logic          ce_rise;
  logic          ce_q;
  logic          wd_fire;
  logic          sp_fire;
  logic          hard_reset;

  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign mapped = (paddr == ADDR_WD_SEL) || (paddr == ADDR_WD_CLEAR) ||
                  (paddr == ADDR_CAUSE) || (paddr == ADDR_STACK_EN) ||
                  (paddr == ADDR_STATUS);
  assign hard_reset = supply_low || !reset_pin_b;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ce_q <= 1'b0;
    else
      ce_q <= ce_pin;
  end
  assign ce_rise = ce_pin && !ce_q;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d             = s_q;
    s_d.start_pulse = 1'b0;
    s_d.carry_init  = 1'b0;
    wd_fire = (rcw_limit(s_q.wd_sel) != 18'h00000) &&
              (s_q.wd_count >= rcw_limit(s_q.wd_sel) - 18'h00001) &&
              instr_done && (s_q.mode == RCW_RUN) && !halt_active; // RULE8
    sp_fire = (s_q.mode == RCW_RUN) &&
              ((int_stack_fault && s_q.stack_en[BIT_INT_EN]) ||
               (addr_stack_fault && s_q.stack_en[BIT_ADDR_EN])); // RULE17

    // Watchdog count; frozen outside running code
    if ((s_q.mode == RCW_RUN) && !halt_active && instr_done) // RULE9
      s_d.wd_count = s_q.wd_count + 18'h00001;

    case (s_q.mode)
      RCW_PIN_HOLD:
      begin
        s_d.cpu_reset  = 1'b1; // RULE6
        s_d.osc_enable = 1'b0; // RULE6
        if (!hard_reset)
        begin
          s_d.osc_enable = 1'b1; // RULE7
          s_d.carry_init = 1'b1; // RULE7
          s_d.mode       = RCW_HALT_POR;
        end
      end
      RCW_HALT_POR:
      begin
        // Enable rising here is absorbed; one start only
        s_d.ce_seen = 1'b0; // RULE1 RULE2
        if (carry_pulse)
        begin
          s_d.cpu_reset   = 1'b0; // RULE7
          s_d.start_pulse = 1'b1; // RULE1
          s_d.wd_count    = 18'h00000;
          s_d.mode        = RCW_RUN;
        end
      end
      RCW_RUN:
      begin
        if (ce_rise)
          s_d.ce_seen = 1'b1; // RULE3
        if (stop_request)
        begin
          // Backup threshold from the first stopped cycle
          s_d.mode           = RCW_STOPPED;
          s_d.osc_enable     = 1'b0;
          s_d.high_threshold = 1'b0; // RULE4
        end
        else if ((s_q.ce_seen && carry_pulse) || wd_fire || sp_fire)
        begin
          s_d.start_pulse = 1'b1; // RULE3 RULE19 RULE8 RULE17
          s_d.ce_seen     = 1'b0;
          s_d.wd_count    = 18'h00000; // RULE10
        end
      end
      RCW_STOPPED:
      begin
        s_d.osc_enable     = 1'b0;
        s_d.high_threshold = 1'b0; // RULE4
        if (ce_rise || ext_int_wake || port_wake_input)
        begin
          s_d.osc_enable   = 1'b1;
          s_d.half_pending = 1'b1; // RULE4
          s_d.mode         = RCW_CE_WAIT; // RULE5
        end
      end
      RCW_CE_WAIT:
      begin
        // Carry counter is 1 here, so the half-period pulse releases the halt
        if (half_carry_pulse)
        begin
          s_d.high_threshold = 1'b1; // RULE4
          s_d.half_pending   = 1'b0;
          s_d.start_pulse    = 1'b1; // RULE5
          s_d.wd_count       = 18'h00000;
          s_d.mode           = RCW_RUN;
        end
      end
      default:
        s_d.mode = RCW_PIN_HOLD;
    endcase

    if (wd_fire || sp_fire)
      s_d.cause_flag = 1'b1; // RULE11

    // Register writes; write-once bits survive soft resets
    if (wr && (paddr == ADDR_WD_SEL) && !s_q.wd_sel_written)
    begin
      s_d.wd_sel         = pwdata[1:0]; // RULE12 RULE13
      s_d.wd_sel_written = 1'b1; // RULE12
    end
    if (wr && (paddr == ADDR_STACK_EN) && !s_q.stack_en_written)
    begin
      s_d.stack_en         = pwdata[1:0]; // RULE18
      s_d.stack_en_written = 1'b1; // RULE18
    end
    if (wr && (paddr == ADDR_WD_CLEAR) && pwdata[BIT_CLEAR] && !wd_fire)
      s_d.wd_count = 18'h00000; // RULE16

    s_d.rdata = 32'h00000000;
    case (paddr)
      ADDR_WD_SEL:   s_d.rdata = {30'h0, s_q.wd_sel};
      ADDR_CAUSE:    s_d.rdata = {31'h0, s_q.cause_flag};
      ADDR_STACK_EN: s_d.rdata = {30'h0, s_q.stack_en};
      ADDR_STATUS:   s_d.rdata = {27'h0, s_q.mode};
      default:       s_d.rdata = 32'h00000000;
    endcase
    // Read clears, but a new fault in the same cycle wins
    if (rd && (paddr == ADDR_CAUSE) && !(wd_fire || sp_fire))
      s_d.cause_flag = 1'b0; // RULE11

    // Supply fault or pin reset: init state, select and enables reload on supply fault only, write-once locks reopen
    if (hard_reset)
    begin
      s_d.mode             = RCW_PIN_HOLD; // RULE6
      s_d.cpu_reset        = 1'b1;
      // No start or timer load may slip out as the pin falls
      s_d.start_pulse      = 1'b0;
      s_d.carry_init       = 1'b0;
      s_d.osc_enable       = 1'b0;
      s_d.wd_count         = 18'h00000;
      s_d.wd_sel_written   = 1'b0;
      s_d.stack_en_written = 1'b0;
      s_d.cause_flag       = 1'b0;
      s_d.ce_seen          = 1'b0;
      s_d.high_threshold   = 1'b1;
      if (supply_low)
      begin
        s_d.wd_sel   = WD_SEL_RESET; // RULE14
        s_d.stack_en = STACK_EN_RESET;
      end
    end
    if (supply_low && s_q.high_threshold && (s_q.mode == RCW_CE_WAIT))
      s_d.mode = RCW_PIN_HOLD; // RULE4
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q                  <= '0;
      s_q.mode             <= RCW_PIN_HOLD;
      s_q.wd_sel           <= WD_SEL_RESET; // RULE14
      s_q.stack_en         <= STACK_EN_RESET;
      s_q.cpu_reset        <= 1'b1;
      s_q.high_threshold   <= 1'b1;
    end
    else
      s_q <= s_d; // RULE20
  end

  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !mapped;
  assign prdata           = (psel && penable && !pwrite) ? s_d.rdata : 32'h00000000;
  assign cpu_reset        = s_q.cpu_reset;
  assign start_from_zero  = s_q.start_pulse;
  assign osc_enable       = s_q.osc_enable;
  assign carry_init_100ms = s_q.carry_init;
  assign high_threshold   = s_q.high_threshold;

endmodule
`default_nettype wire

// File: sim/rcw_chk.sv
// Checker: timing relations on the reset controller ports.
// Assumes it is bound into rcw_reset_controller, one clock domain.
`default_nettype none
module rcw_chk
  import rcw_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        supply_low,
  input wire logic        reset_pin_b,
  input wire logic        half_carry_pulse,
  input wire logic        instr_done,
  input wire logic        stop_request,
  input wire logic        int_stack_fault,
  input wire logic        addr_stack_fault,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        cpu_reset,
  input wire logic        start_from_zero,
  input wire logic        osc_enable,
  input wire logic        carry_init_100ms,
  input wire logic        high_threshold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_cause = psel && penable && !pwrite && paddr == ADDR_CAUSE;
  // Faults or instructions could set the flag again between reads
  wire quiet = !int_stack_fault && !addr_stack_fault && !instr_done;
  //////////////////////////////////////////////////////////////
  AST_PIN_HOLD: assert property (!reset_pin_b ##1 !reset_pin_b |-> cpu_reset && !osc_enable)
    else $error("core not held while reset pin low");
  AST_PIN_QUIET: assert property (!reset_pin_b |=> !start_from_zero && !carry_init_100ms)
    else $error("start or timer load while reset pin low");
  AST_PIN_RELEASE: assert property ($rose(reset_pin_b) |=> carry_init_100ms && osc_enable)
    else $error("no timer load after reset pin release");
  AST_INIT_PULSE: assert property (carry_init_100ms |-> osc_enable ##1 !carry_init_100ms)
    else $error("timer load not a single pulse with oscillator on");
  AST_START_ONE: assert property (start_from_zero |=> !start_from_zero)
    else $error("start pulse longer than one cycle");
  AST_THR_LOW: assert property ($fell(high_threshold) |-> $past(stop_request))
    else $error("threshold lowered without clock stop");
  AST_THR_HIGH: assert property ($rose(high_threshold) |->
      $past(half_carry_pulse) || $past(supply_low) || !$past(reset_pin_b))
    else $error("threshold raised without half carry");
  AST_CAUSE_CLR: assert property (rd_cause && quiet ##1 quiet ##1 quiet ##1 rd_cause |->
      !prdata[0])
    else $error("cause flag not cleared by read");
endmodule
bind rcw_reset_controller rcw_chk u_chk (.clk, .rst_b, .supply_low, .reset_pin_b,
  .half_carry_pulse, .instr_done, .stop_request, .int_stack_fault, .addr_stack_fault,
  .psel, .penable, .pwrite, .paddr, .prdata, .cpu_reset, .start_from_zero, .osc_enable,
  .carry_init_100ms, .high_threshold);
`default_nettype wire

// File: sim/rcw_board.sv
// Board and core model: basic timer carry pulses and instruction strobes.
// Assumes the bench gates instructions through run.
`default_nettype none
module rcw_board
#(
  parameter int CARRY_PERIOD = 40
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      carry_pulse,
  output logic      instr_done
);
  logic [7:0] cnt_q;
  // Short carry period stands in for the 100 ms timer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q       <= 8'h00;
      carry_pulse <= 1'b0;
    end
    else
    begin
      cnt_q       <= (cnt_q == 8'(CARRY_PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      carry_pulse <= (cnt_q == 8'(CARRY_PERIOD - 1));
    end
  end
  assign instr_done = run;
endmodule
`default_nettype wire

// File: sim/reset_controller_with_watchdog_bench.sv
// Bench of the reset controller: APB master, pins and watchdog traffic.
// Assumes rcw_board and rcw_chk are compiled first.
`default_nettype none
module reset_controller_with_watchdog_bench;
  import rcw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, supply_low, ce_pin, reset_pin_b, carry_pulse, half_carry_pulse;
  logic        instr_done, halt_active, stop_request, ext_int_wake, port_wake_input, run;
  logic        int_stack_fault, addr_stack_fault, psel, penable, pwrite, pready, pslverr;
  logic        cpu_reset, start_from_zero, osc_enable, carry_init_100ms, high_threshold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] exp_q[$];
  int          n_fail, n_checks, n_start, cyc, k;
  //////////////////////////////////////////////////////////////
  rcw_reset_controller uut (.clk, .rst_b, .supply_low, .ce_pin, .reset_pin_b, .carry_pulse,
    .half_carry_pulse, .instr_done, .halt_active, .stop_request, .ext_int_wake,
    .port_wake_input, .int_stack_fault, .addr_stack_fault, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .cpu_reset, .start_from_zero,
    .osc_enable, .carry_init_100ms, .high_threshold);
  rcw_board #(.CARRY_PERIOD(40)) u_board (.clk, .rst_b, .run, .carry_pulse, .instr_done);
  //////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Read notes its expected word; the monitor below compares it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? (($urandom() & 32'hFFFFFFFC) | d) : 32'h0;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ends once pready is high; the bench timeout ends a stalled wait
    while (pready !== 1'b1)
      @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic instrs(input int n);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask
  task automatic wait_starts(input int n, input int d);
    k = n_start;
    repeat (n) @(posedge clk);
    check("start count", 32'(n_start - k), 32'(d));
  endtask
  //////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (start_from_zero === 1'b1)
      n_start++;
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", prdata, exp_q.pop_front());
    if (psel && penable && pready === 1'b1)
      check("pslverr", 32'(pslverr), 32'(paddr == 12'h0F0));
    if (cyc == 80000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    {rst_b, supply_low, ce_pin, half_carry_pulse, halt_active, stop_request} = '0;
    {ext_int_wake, port_wake_input, run, int_stack_fault, addr_stack_fault} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_pin_b = 1'b1;
    void'($urandom(32'hF1DB));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    ce_pin <= 1'b1;
    wait_starts(100, 1);
    ce_pin <= 1'b0;
    @(posedge clk);
    ce_pin <= 1'b1;
    wait_starts(45, 1);
    $display("test power and enable done");
    apb(0, ADDR_WD_SEL, 32'h3);
    apb(0, ADDR_STACK_EN, 32'h3);
    apb(1, ADDR_WD_SEL, 32'h1);
    apb(1, ADDR_WD_SEL, 32'h3);
    apb(1, ADDR_STACK_EN, 32'h1);
    apb(1, ADDR_STACK_EN, 32'h3);
    apb(0, ADDR_WD_SEL, 32'h1);
    apb(0, ADDR_STACK_EN, 32'h1);
    apb(0, 12'h0F0, 32'h0);
    addr_stack_fault <= 1'b1;
    @(posedge clk);
    addr_stack_fault <= 1'b0;
    apb(0, ADDR_CAUSE, 32'h0);
    int_stack_fault <= 1'b1;
    @(posedge clk);
    int_stack_fault <= 1'b0;
    apb(0, ADDR_CAUSE, 32'h1);
    apb(0, ADDR_CAUSE, 32'h0);
    apb(0, ADDR_STACK_EN, 32'h1);
    $display("test registers and stack done");
    repeat (45) @(posedge clk);
    instrs(300);
    apb(1, ADDR_WD_CLEAR, 32'h1);
    instrs(65535);
    halt_active <= 1'b1;
    instrs(8);
    halt_active <= 1'b0;
    apb(0, ADDR_CAUSE, 32'h0);
    k = n_start;
    instrs(1);
    apb(0, ADDR_CAUSE, 32'h1);
    apb(0, ADDR_WD_SEL, 32'h1);
    check("start count", 32'(n_start - k), 32'h1);
    $display("test watchdog done");
    stop_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    repeat (4) @(posedge clk);
    check("threshold", 32'(high_threshold), 32'h0);
    k = n_start;
    port_wake_input <= 1'b1;
    repeat (3) @(posedge clk);
    port_wake_input  <= 1'b0;
    half_carry_pulse <= 1'b1;
    @(posedge clk);
    half_carry_pulse <= 1'b0;
    repeat (3) @(posedge clk);
    check("threshold", 32'(high_threshold), 32'h1);
    check("start count", 32'(n_start - k), 32'h1);
    $display("test clock stop done");
    reset_pin_b <= 1'b0;
    repeat (4) @(posedge clk);
    reset_pin_b <= 1'b1;
    wait_starts(90, 1);
    apb(1, ADDR_WD_SEL, 32'h0);
    apb(0, ADDR_WD_SEL, 32'h0);
    $display("test reset pin done");
    ce_pin     <= 1'b0;
    supply_low <= 1'b1;
    repeat (3) @(posedge clk);
    supply_low <= 1'b0;
    ce_pin     <= 1'b1;
    wait_starts(90, 1);
    apb(0, ADDR_WD_SEL, 32'h3);
    apb(0, ADDR_STACK_EN, 32'h3);
    $display("test supply application done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
